// *** hw/lcdcd_pkg.sv ***
// Package for the LCD driver command decoder: opcodes, resets, timing.
// Assumes a single 125 MHz clock domain.
package lcdcd_pkg;
   // Column and page limits, reset values
   localparam logic [7:0] COL_LAST      = 8'hA0;
   localparam logic [7:0] COL_RST       = 8'h00;
   localparam logic [2:0] PAGE_RST      = 3'h0;
   localparam logic [2:0] PAGE_ICON     = 3'h4;
   localparam logic [3:0] CONTRAST_RST  = 4'h0;
   // Opcodes with bit 0 as operand (compare bits 7..1)
   localparam logic [6:0] OP_DISP_ONOFF = 7'h57; // 1010111D
   localparam logic [6:0] OP_SEG_DIR    = 7'h50; // 1010000D
   localparam logic [6:0] OP_INVERT     = 7'h53; // 1010011D
   localparam logic [6:0] OP_ALL_ON     = 7'h52; // 1010010D
   localparam logic [6:0] OP_ICON       = 7'h55; // 1010101D
   localparam logic [6:0] OP_SUPPLY     = 7'h12; // 0010010D
   // Full-byte opcodes
   localparam logic [7:0] OP_RMW_ENTER  = 8'hE0;
   localparam logic [7:0] OP_RMW_END    = 8'hEE;
   localparam logic [7:0] OP_SOFT_RST   = 8'hE2;
   localparam logic [7:0] OP_DRV_SET    = 8'hED;
   // Nibble opcodes (bits 7..4); page opcode bits 7..3
   localparam logic [3:0] OP_COL_HI     = 4'h1;
   localparam logic [3:0] OP_COL_LO     = 4'h0;
   localparam logic [3:0] OP_CONTRAST   = 4'h8;
   localparam logic [3:0] OP_COM_ORDER  = 4'hC;
   localparam logic [4:0] OP_PAGE       = 5'h16; // 10110PPP
   // Busy and reset cycle lengths
   localparam int RESET_NS      = 1000;
   localparam int CLK_PERIOD_NS = 8;
   localparam int RESET_CYC     = (RESET_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int BUSY_CYC      = 2;
   // Serial byte width
   localparam int SER_BITS      = 8;

   // Bus cycle carrier
   typedef struct packed {
      logic       sel;
      logic       wr;
      logic       rd;
      logic [7:0] data;
   } lcdcd_bus_s;

   // Display mode carrier
   typedef struct packed {
      logic disp_on;
      logic seg_rev;
      logic invert;
      logic all_on;
      logic icon_on;
      logic com_rev;
      logic supply_on;
      logic power_save;
   } lcdcd_mode_s;
endpackage

// *** hw/lcdcd_serial_rx.sv ***
// Serial receiver: shifts bytes in, most significant bit first.
// Assumes bit strobe and serial data synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module lcdcd_serial_rx
#(
   parameter int BITS = lcdcd_pkg::SER_BITS
)
(
   input  wire logic            clock,
   input  wire logic            sys_rst,
   input  wire logic            clear,
   input  wire logic            bit_valid,
   input  wire logic            bit_in,
   output var  logic            byte_valid,
   output var  logic [BITS-1:0] byte_out
);
   logic [BITS-1:0] shift_r;
   logic [3:0]      count_r;
   wire             last_bit = (count_r == 4'(BITS - 1));
   wire [BITS-1:0]  shift_nxt = {shift_r[BITS-2:0], bit_in};

   // Shift left so the first bit lands on top
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         shift_r    <= '0;
         count_r    <= 4'h0;
         byte_valid <= 1'b0;
         byte_out   <= '0;
      end
      else
      begin
         byte_valid <= 1'b0;
         if (clear)
         begin
            shift_r <= '0;
            count_r <= 4'h0;
         end
         else if (bit_valid)
         begin
            shift_r <= shift_nxt; // see RULE2
            count_r <= last_bit ? 4'h0 : count_r + 4'h1;
            if (last_bit)
            begin
               byte_valid <= 1'b1;
               byte_out   <= shift_nxt;
            end
         end
      end
   end

   a_msb_first_order: assert property (@(posedge clock) disable iff (sys_rst)
      bit_valid && last_bit && !clear |=> byte_valid && byte_out[0] == $past(bit_in))
      else $error("serial byte not assembled msb first"); // see RULE2
endmodule
`default_nettype wire

// *** hw/lcdcd_top.sv ***
// Command decoder and host port of a bit-map LCD driver.
// Assumes host strobes synchronous to clock, one cycle each.
//
// Overview of operation
// RULE1 - Select and strobes classify each bus cycle
// RULE2 - Serial bytes arrive most significant bit first
// RULE3 - Execution timed internally, busy rarely needs polling
// RULE4 - Display on/off from bit 0, memory untouched
// RULE5 - Page command picks page zero to four
// RULE6 - Page four holds icons, bit 0 only
// RULE7 - Column loaded by high, low nibble commands
// RULE8 - Data access advances column, stops at A0
// RULE9 - Host must reissue page after each page
// RULE10 - Status byte: busy, direction, display, reset
// RULE11 - Busy high during operations and reset cycles
// RULE12 - Direction status one means normal mapping
// RULE13 - Display status inverted; reset flag during init
// RULE14 - Data write stores byte, then increments column
// RULE15 - First read after column set is dummy
// RULE16 - Direction and pixel polarity from bit 0
// RULE17 - All pixels on command from bit 0
// RULE18 - Icon command picks 1/32 or 1/33 duty
// RULE19 - Read-modify-write: reads keep column, writes advance
// RULE20 - Soft reset command reinitialises address registers
// RULE21 - Scan order bit and contrast register load
// RULE22 - Supply command switches internal supply circuits
// RULE23 - First strap low enables all supply functions
// RULE24 - Straps high-low disable step-up only
// RULE25 - Both straps high leave follower only
// RULE26 - Display off then all-on enters power save
// RULE27 - End restores column saved at mode entry
// RULE28 - Column set releases the final-address lock
// RULE29 - Unknown commands change no state
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module lcdcd_top
#(
   parameter int PAGES = 5,
   parameter int COLS  = 161
)
(
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   input  wire logic                  hardware_reset_n,
   input  wire logic                  serial_mode,
   input  wire logic                  ser_bit_valid,
   input  wire logic                  ser_bit,
   input  wire logic                  cmd_data_select,
   input  wire logic                  wr_strobe,
   input  wire logic                  rd_strobe,
   input  wire logic [7:0]            wr_data,
   input  wire logic                  supply_strap_first,
   input  wire logic                  supply_strap_second,
   output var  logic [7:0]            rd_data,
   output var  logic                  rd_valid,
   output var  lcdcd_pkg::lcdcd_mode_s mode_out,
   output var  logic [3:0]            contrast_register,
   output var  logic                  step_up_en,
   output var  logic                  voltage_adjust_pin,
   output var  logic                  follower_en,
   output var  logic                  icon_common_line
);
   ////////////////////////////////////////////////////////////////////////
   // Serial front end
   logic       ser_valid;
   logic [7:0] ser_byte;
   logic       init_r;

   lcdcd_serial_rx #(.BITS(lcdcd_pkg::SER_BITS)) u_ser
   (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .clear      (init_r),
      .bit_valid  (ser_bit_valid & serial_mode),
      .bit_in     (ser_bit),
      .byte_valid (ser_valid),
      .byte_out   (ser_byte)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus cycle classification
   lcdcd_pkg::lcdcd_bus_s bus;
   assign bus.sel  = cmd_data_select;
   assign bus.wr   = serial_mode ? ser_valid : wr_strobe;
   assign bus.rd   = serial_mode ? 1'b0 : rd_strobe; // see RULE15
   assign bus.data = serial_mode ? ser_byte : wr_data;

   // Command only accepted when idle; status read always allowed
   logic busy_r;
   wire cmd_wr  = bus.wr && !bus.sel && !busy_r;   // see RULE1
   wire dat_wr  = bus.wr &&  bus.sel && !busy_r;   // see RULE1
   wire dat_rd  = bus.rd &&  bus.sel && !busy_r;   // see RULE1
   wire stat_rd = bus.rd && !bus.sel;              // see RULE10

   ////////////////////////////////////////////////////////////////////////
   // Opcode decode
   wire [7:0] op = bus.data;
   wire is_disp   = cmd_wr && op[7:1] == lcdcd_pkg::OP_DISP_ONOFF;
   wire is_segdir = cmd_wr && op[7:1] == lcdcd_pkg::OP_SEG_DIR;
   wire is_inv    = cmd_wr && op[7:1] == lcdcd_pkg::OP_INVERT;
   wire is_allon  = cmd_wr && op[7:1] == lcdcd_pkg::OP_ALL_ON;
   wire is_icon   = cmd_wr && op[7:1] == lcdcd_pkg::OP_ICON;
   wire is_supply = cmd_wr && op[7:1] == lcdcd_pkg::OP_SUPPLY;
   wire is_page   = cmd_wr && op[7:3] == lcdcd_pkg::OP_PAGE
                   && op[2:0] <= lcdcd_pkg::PAGE_ICON;
   wire is_colhi  = cmd_wr && op[7:4] == lcdcd_pkg::OP_COL_HI;
   wire is_collo  = cmd_wr && op[7:4] == lcdcd_pkg::OP_COL_LO;
   wire is_contr  = cmd_wr && op[7:4] == lcdcd_pkg::OP_CONTRAST;
   wire is_comord = cmd_wr && op[7:4] == lcdcd_pkg::OP_COM_ORDER;
   wire is_rmw_in = cmd_wr && op == lcdcd_pkg::OP_RMW_ENTER;
   wire is_rmw_ex = cmd_wr && op == lcdcd_pkg::OP_RMW_END;
   wire is_srst   = cmd_wr && op == lcdcd_pkg::OP_SOFT_RST;
   wire is_colset = is_colhi || is_collo;

   ////////////////////////////////////////////////////////////////////////
   // Reset sequencing: pin or soft command starts an init period
   logic [7:0] init_cnt_r;
   wire        pin_rst = !hardware_reset_n;
   wire        soft_go = is_srst;

   // Init flag held for the whole reset period
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         init_r     <= 1'b1;
         init_cnt_r <= 8'(lcdcd_pkg::RESET_CYC);
      end
      else if (pin_rst || soft_go)
      begin
         init_r     <= 1'b1; // see RULE13
         init_cnt_r <= 8'(lcdcd_pkg::RESET_CYC);
      end
      else if (init_cnt_r != 8'h00)
         init_cnt_r <= init_cnt_r - 8'h01;
      else
         init_r <= 1'b0;
   end

   // Busy covers each command and the whole init period
   logic [1:0] busy_cnt_r;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busy_r     <= 1'b1;
         busy_cnt_r <= 2'h0;
      end
      else
      begin
         if (cmd_wr || dat_wr || dat_rd)
            busy_cnt_r <= 2'(lcdcd_pkg::BUSY_CYC - 1);
         else if (busy_cnt_r != 2'h0)
            busy_cnt_r <= busy_cnt_r - 2'h1;
         // Internal timing only: no host clock involved
         busy_r <= init_r || pin_rst || soft_go
                   || cmd_wr || dat_wr || dat_rd
                   || busy_cnt_r != 2'h0; // see RULE3 see RULE11
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode registers; pin reset clears all, soft reset only scan order
   lcdcd_pkg::lcdcd_mode_s mode_r;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         mode_r <= '0;
      else if (pin_rst)
         mode_r <= '0;
      else
      begin
         if (is_disp)   mode_r.disp_on   <= op[0]; // see RULE4
         if (is_segdir) mode_r.seg_rev   <= op[0]; // see RULE16
         if (is_inv)    mode_r.invert    <= op[0]; // see RULE16
         if (is_allon)  mode_r.all_on    <= op[0]; // see RULE17
         if (is_icon)   mode_r.icon_on   <= op[0]; // see RULE18
         if (is_comord) mode_r.com_rev   <= op[3]; // see RULE21
         if (soft_go)   mode_r.com_rev   <= 1'b0;  // see RULE20
         if (is_supply) mode_r.supply_on <= op[0]; // see RULE22
         // Off followed by all-on parks the panel
         if (is_allon && op[0] && !mode_r.disp_on)
            mode_r.power_save <= 1'b1; // see RULE26
         else if (is_inv && mode_r.power_save)
            mode_r.power_save <= 1'b0;
      end
   end

   // Contrast also cleared by the soft reset
   logic [3:0] contrast_r;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         contrast_r <= lcdcd_pkg::CONTRAST_RST;
      else if (pin_rst || soft_go)
         contrast_r <= lcdcd_pkg::CONTRAST_RST; // see RULE20
      else if (is_contr)
         contrast_r <= op[3:0]; // see RULE21
   end

   ////////////////////////////////////////////////////////////////////////
   // Page and column addressing
   logic [2:0] page_r;
   logic [7:0] col_r;
   logic [7:0] col_save_r;
   logic       rmw_r;
   logic       dummy_r;
   wire        at_last  = (col_r == lcdcd_pkg::COL_LAST);
   // Writes advance until the last column; reads only outside read-modify-write
   wire        advance  = (dat_wr || (dat_rd && !rmw_r))
                          && !at_last; // see RULE8 see RULE19
   wire [7:0]  col_nxt  = is_colhi ? {op[3:0], col_r[3:0]}
                        : is_collo ? {col_r[7:4], op[3:0]}
                        : is_rmw_ex && rmw_r ? col_save_r
                        : advance ? col_r + 8'h01
                        : col_r;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         page_r <= lcdcd_pkg::PAGE_RST;
         col_r  <= lcdcd_pkg::COL_RST;
      end
      else if (pin_rst || soft_go)
      begin
         page_r <= lcdcd_pkg::PAGE_RST; // see RULE20
         col_r  <= lcdcd_pkg::COL_RST;
      end
      else
      begin
         if (is_page)
            page_r <= op[2:0]; // see RULE5 see RULE9
         col_r <= col_nxt; // see RULE7 see RULE28 see RULE27
      end
   end

   // Read-modify-write entry point and mode flag
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rmw_r      <= 1'b0;
         col_save_r <= lcdcd_pkg::COL_RST;
      end
      else if (pin_rst)
         rmw_r <= 1'b0;
      else if (is_rmw_in)
      begin
         rmw_r      <= 1'b1; // see RULE19
         col_save_r <= col_r;
      end
      else if (is_rmw_ex)
         rmw_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Display memory in flip-flops; one byte per page and column
   logic [7:0] mem_r [PAGES][COLS];
   wire        in_range = (col_r < 8'(COLS));
   // Icon page keeps only bit 0
   wire [7:0]  wdata    = (page_r == lcdcd_pkg::PAGE_ICON)
                          ? {7'h00, bus.data[0]} : bus.data; // see RULE6

   always_ff @(posedge clock)
   begin
      if (dat_wr && in_range)
         mem_r[page_r][col_r] <= wdata; // see RULE14
   end

   // Read pipeline: host sees the previously latched byte
   logic [7:0] latch_r;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         dummy_r <= 1'b1;
      else if (is_colset)
         dummy_r <= 1'b1;
      else if (dat_rd)
         dummy_r <= 1'b0; // see RULE15
   end

   wire [7:0] mem_word = in_range ? mem_r[page_r][col_r] : 8'hFF;
   wire [7:0] status   = {busy_r, !mode_r.seg_rev, !mode_r.disp_on,
                          init_r, 4'h0}; // see RULE10 see RULE12 see RULE13

   // Read data stand one cycle after the strobe
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         latch_r  <= 8'h00;
         rd_data  <= 8'h00;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= stat_rd || dat_rd;
         if (dat_rd)
            latch_r <= mem_word;
         rd_data <= stat_rd ? status
                  : dat_rd  ? latch_r
                  : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Supply control gated by the straps
   wire strap_step = !supply_strap_first;                         // see RULE23
   wire strap_vadj = !supply_strap_first || !supply_strap_second; // see RULE24
   wire run        = mode_r.supply_on && !mode_r.power_save;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         step_up_en         <= 1'b0;
         voltage_adjust_pin <= 1'b0;
         follower_en        <= 1'b0;
         icon_common_line   <= 1'b0;
         mode_out           <= '0;
         contrast_register  <= lcdcd_pkg::CONTRAST_RST;
      end
      else
      begin
         step_up_en         <= run && strap_step; // see RULE24
         voltage_adjust_pin <= run && strap_vadj; // see RULE25
         follower_en        <= run;               // see RULE25
         icon_common_line   <= mode_r.icon_on;    // see RULE18
         mode_out           <= mode_r;
         contrast_register  <= contrast_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_colset;
      is_colset;
   endsequence
   sequence s_first_read;
      dat_rd && dummy_r;
   endsequence

   a_col_stop_hold: assert property (@(posedge clock) disable iff (sys_rst)
      at_last && (dat_wr || dat_rd) && !is_colset && !pin_rst
      |=> col_r == lcdcd_pkg::COL_LAST)
      else $error("column moved past last"); // see RULE8
   a_write_incr: assert property (@(posedge clock) disable iff (sys_rst)
      dat_wr && !at_last && !pin_rst |=> col_r == $past(col_r) + 8'h01)
      else $error("write did not advance column"); // see RULE14
   a_rmw_read_hold: assert property (@(posedge clock) disable iff (sys_rst)
      rmw_r && dat_rd && !pin_rst |=> col_r == $past(col_r))
      else $error("read moved column in rmw"); // see RULE19
   a_status_layout: assert property (@(posedge clock) disable iff (sys_rst)
      stat_rd |=> rd_valid && rd_data[3:0] == 4'h0
                  && rd_data[5] == !$past(mode_r.disp_on))
      else $error("status byte malformed"); // see RULE10
   a_disp_status_inv: assert property (@(posedge clock) disable iff (sys_rst)
      is_disp && !pin_rst |=> status[5] == !$past(op[0]))
      else $error("display status not inverted"); // see RULE13
   a_dummy_after_set: assert property (@(posedge clock) disable iff (sys_rst)
      s_colset ##1 (!is_colset && !dat_rd) [*1] ##0 1'b1 |-> dummy_r)
      else $error("dummy flag not armed"); // see RULE15
   a_dummy_clears: assert property (@(posedge clock) disable iff (sys_rst)
      s_first_read and (!is_colset) |=> !dummy_r)
      else $error("dummy flag stuck"); // see RULE15
   a_page_stable: assert property (@(posedge clock) disable iff (sys_rst)
      (dat_wr || dat_rd) && !is_page && !pin_rst |=> $stable(page_r))
      else $error("page changed by data access"); // see RULE8
   a_end_restores: assert property (@(posedge clock) disable iff (sys_rst)
      is_rmw_ex && rmw_r && !pin_rst |=> col_r == $past(col_save_r))
      else $error("end did not restore column"); // see RULE27
   a_strap_step_off: assert property (@(posedge clock) disable iff (sys_rst)
      supply_strap_first ##1 supply_strap_first |-> !step_up_en)
      else $error("step-up on while strapped off"); // see RULE24
   a_both_straps: assert property (@(posedge clock) disable iff (sys_rst)
      supply_strap_first && supply_strap_second
      ##1 supply_strap_first && supply_strap_second |-> !voltage_adjust_pin)
      else $error("adjust on with both straps"); // see RULE25
   a_unknown_cmd: assert property (@(posedge clock) disable iff (sys_rst)
      cmd_wr && op[7:4] == 4'hF && !pin_rst
      |=> $stable(col_r) && $stable(page_r) && $stable(contrast_r)
          && $stable(mode_r))
      else $error("unknown command changed state"); // see RULE29
   a_busy_after_cmd: assert property (@(posedge clock) disable iff (sys_rst)
      cmd_wr |=> busy_r)
      else $error("busy not raised"); // see RULE11
   a_contrast_load: assert property (@(posedge clock) disable iff (sys_rst)
      is_contr && !pin_rst |=> ##1 contrast_register == $past(op[3:0], 2))
      else $error("contrast not loaded"); // see RULE21
endmodule
`default_nettype wire

// *** tb/lcdcd_host_ser.sv ***
// Host-side serial sender: one byte out, most significant bit first.
// Assumes the bench pulses start for one cycle with byte_in held.
`timescale 1ns/1ps
`default_nettype none
module lcdcd_host_ser
(
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       start,
   input  wire logic [7:0] byte_in,
   output var  logic       ser_bit_valid,
   output var  logic       ser_bit,
   output var  logic       busy
);
   logic [7:0] shf_r;
   logic [4:0] cnt_r;
   logic       send;

   // Even counts carry a bit, odd counts are gaps
   assign send = !start && (cnt_r != 5'h00) && !cnt_r[0];
   assign busy = (cnt_r != 5'h00);

   ////////////////////////////////////////////////////////////////////
   // Gap and idle toggle the line so a stale bit is never read as good
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cnt_r         <= 5'h00;
         shf_r         <= 8'h00;
         ser_bit       <= 1'b0;
         ser_bit_valid <= 1'b0;
      end
      else
      begin
         ser_bit_valid <= send;
         ser_bit       <= send ? shf_r[7] : ~ser_bit;
         if (start)
            cnt_r <= 5'h10;
         else if (busy)
            cnt_r <= cnt_r - 5'h01;
         if (start)
            shf_r <= byte_in;
         else if (send)
            shf_r <= {shf_r[6:0], 1'b0};
      end
   end
endmodule
`default_nettype wire

// *** tb/tb_lcdcd_top.sv ***
// Bench for the LCD command decoder: parallel and serial host traffic.
// Assumes the decoder answers reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module tb_lcdcd_top;
   logic       clock, sys_rst, hardware_reset_n, serial_mode;
   logic       ser_bit_valid, ser_bit, cmd_data_select, wr_strobe;
   logic       rd_strobe, strap1, strap2, rd_valid, ser_start, ser_busy;
   logic [7:0] wr_data, rd_data, ser_byte;
   logic [3:0] contrast_register;
   logic       step_up_en, voltage_adjust_pin, follower_en;
   logic       icon_common_line, rv;
   lcdcd_pkg::lcdcd_mode_s mode_out;
   int         err_count, tests_run, cyc;

   lcdcd_top i_dut (.clock(clock), .sys_rst(sys_rst),
      .hardware_reset_n(hardware_reset_n), .serial_mode(serial_mode),
      .ser_bit_valid(ser_bit_valid), .ser_bit(ser_bit),
      .cmd_data_select(cmd_data_select), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .wr_data(wr_data),
      .supply_strap_first(strap1), .supply_strap_second(strap2),
      .rd_data(rd_data), .rd_valid(rd_valid), .mode_out(mode_out),
      .contrast_register(contrast_register), .step_up_en(step_up_en),
      .voltage_adjust_pin(voltage_adjust_pin), .follower_en(follower_en),
      .icon_common_line(icon_common_line));

   lcdcd_host_ser i_host (.clock(clock), .sys_rst(sys_rst),
      .start(ser_start), .byte_in(ser_byte), .ser_bit_valid(ser_bit_valid),
      .ser_bit(ser_bit), .busy(ser_busy));

   ////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the run needs under a thousand cycles
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         summarize();
      end
   end

   // Bus cycles spaced so busy has cleared before the next strobe
   task automatic wr(input logic sel, input logic [7:0] d);
      @(posedge clock);
      cmd_data_select <= sel;
      wr_data         <= d;
      wr_strobe       <= 1'b1;
      @(posedge clock);
      wr_strobe <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   task automatic rd(input logic sel, output logic [7:0] d);
      @(posedge clock);
      cmd_data_select <= sel;
      rd_strobe       <= 1'b1;
      @(posedge clock);
      rd_strobe <= 1'b0;
      #1 d = rd_data;
      rv = rd_valid;
      repeat (3) @(posedge clock);
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Poll status until not busy, bounded
   task automatic rdy;
      logic [7:0] s;
      int         n;
      s = 8'hFF;
      n = 0;
      while (s[7] !== 1'b0 && n < 300)
      begin
         rd(1'b0, s);
         n++;
      end
      if (n == 300)
         err_count++;
   endtask
   task automatic col(input logic [7:0] c);
      wr(1'b0, {4'h1, c[7:4]});
      wr(1'b0, {4'h0, c[3:0]});
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence; mode table lists command and expected mode byte
   initial
   begin
      logic [7:0] s;
      logic [7:0] tc [18];
      logic [7:0] tm [18];
      tc = '{8'hAF, 8'hA1, 8'hA7, 8'hA5, 8'hAB, 8'hC8, 8'h25, 8'hA4, 8'hA6,
             8'hA0, 8'hAA, 8'hC0, 8'h24, 8'hF0, 8'hAE, 8'hA5, 8'hA6, 8'hA4};
      tm = '{8'h80, 8'hC0, 8'hE0, 8'hF0, 8'hF8, 8'hFC, 8'hFE, 8'hEE, 8'hCE,
             8'h8E, 8'h86, 8'h82, 8'h80, 8'h80, 8'h00, 8'h11, 8'h10, 8'h00};
      {sys_rst, hardware_reset_n, serial_mode, cmd_data_select} = 4'hC;
      {wr_strobe, rd_strobe, strap1, strap2, ser_start} = 5'h00;
      {wr_data, ser_byte} = 16'h0000;
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      rd(1'b0, s);
      chk(s, 8'hF0);
      chk(rv, 8'h01);
      rdy();
      rd(1'b0, s);
      chk(s, 8'h60);
      $display("test reset done");
      for (int i = 0; i < 18; i++)
      begin
         wr(1'b0, tc[i]);
         chk(mode_out, tm[i]);
         rd(1'b0, s);
         chk(s, {1'b0, ~tm[i][6], ~tm[i][7], 5'h00});
      end
      wr(1'b0, 8'hAB);
      chk(icon_common_line, 8'h01);
      $display("test modes done");
      wr(1'b0, 8'h25);
      for (int i = 0; i < 4; i++)
      begin
         {strap1, strap2} <= i[1:0];
         repeat (3) @(posedge clock);
         chk({step_up_en, voltage_adjust_pin, follower_en},
             i[1] ? (i[0] ? 8'h01 : 8'h03) : 8'h07);
      end
      wr(1'b0, 8'h24);
      chk({step_up_en, voltage_adjust_pin, follower_en}, 8'h00);
      $display("test supply done");
      wr(1'b0, 8'hB0);
      col(8'h9F);
      wr(1'b1, 8'h11);
      wr(1'b1, 8'h22);
      wr(1'b1, 8'h33);
      wr(1'b0, 8'hB1);
      col(8'h9F);
      wr(1'b1, 8'h44);
      wr(1'b0, 8'hB0);
      col(8'h9F);
      rd(1'b1, s);
      rd(1'b1, s);
      chk(s, 8'h11);
      rd(1'b1, s);
      chk(s, 8'h33);
      rd(1'b1, s);
      chk(s, 8'h33);
      wr(1'b0, 8'hB4);
      col(8'h00);
      wr(1'b1, 8'hFF);
      col(8'h00);
      rd(1'b1, s);
      rd(1'b1, s);
      chk(s, 8'h01);
      wr(1'b0, 8'hB0);
      $display("test memory done");
      col(8'h05);
      wr(1'b1, 8'h5A);
      col(8'h05);
      wr(1'b0, 8'hE0);
      rd(1'b1, s);
      rd(1'b1, s);
      chk(s, 8'h5A);
      wr(1'b1, 8'hA5);
      wr(1'b0, 8'hEE);
      wr(1'b1, 8'h77);
      col(8'h05);
      rd(1'b1, s);
      rd(1'b1, s);
      chk(s, 8'h77);
      $display("test rmw done");
      wr(1'b0, 8'h8B);
      chk(contrast_register, 8'h0B);
      wr(1'b0, 8'hC8);
      wr(1'b0, 8'hE2);
      rdy();
      chk({contrast_register, 3'h0, mode_out.com_rev}, 8'h00);
      wr(1'b0, 8'h8B);
      hardware_reset_n <= 1'b0;
      repeat (3) @(posedge clock);
      hardware_reset_n <= 1'b1;
      rdy();
      chk({contrast_register, mode_out[7:4]}, 8'h00);
      chk(mode_out, 8'h00);
      $display("test reset paths done");
      serial_mode <= 1'b1;
      ser_byte    <= 8'h8C;
      ser_start   <= 1'b1;
      @(posedge clock);
      ser_start <= 1'b0;
      repeat (24) @(posedge clock);
      chk(contrast_register, 8'h0C);
      wr(1'b0, 8'h81);
      rd(1'b1, s);
      chk({contrast_register, s[3:0]}, 8'hC0);
      chk(rv, 8'h00);
      serial_mode <= 1'b0;
      $display("test serial done");
      summarize();
   end
endmodule
`default_nettype wire
